// *** rtl/mcc_top.sv ***
// MAC control word: APB register slave, speed and duplex selection, soft reset and pause timer.
// Overview of operation
// - Control bit 0 enables the transmit datapath; zero keeps it disabled.
// - Control bit 1 enables the receive datapath; zero keeps it disabled.
// - Hardware reset and finished soft reset clear both datapath enables.
// - Operation starts once both enables are set; software sets them last.
// - Bit 2 requests a zero-quanta pause frame regardless of FIFO fill.
// - Bit 3 set forces gigabit and ignores the external gigabit request.
// - Bit 3 clear: gigabit only while the request pin is asserted.
// - Gigabit indicator output follows the actual operating speed.
// - Bit 4 accepts all received frames without address filtering.
// - Bit 5 strips receive padding; transmit frames are unaffected.
// - Bit 6 set forwards the received FCS; clear removes it.
// - Padded frame with pad removal on: FCS bit ignored, FCS removed.
// - Bit 7 set forwards received pause frames; clear discards them.
// - Bit 8 set ignores pause frames; clear halts transmit for quanta.
// - Bit 9 overwrites the transmit source address; clear keeps it.
// - Bit 10 selects half duplex, ignored while the speed bit is set.
// - Bit 11 flags a frame dropped after 16 collisions; resets clear it.
// - Soft reset: finish frame, disable paths, flush FIFO, clear stats.
//
// Decided for this implementation: the APB register port.
`default_nettype none

module mcc_top (
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  // APB slave.
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [9:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output var logic [31:0] PRDATA_O,
  output var logic PREADY_O,
  output var logic PSLVERR_O,
  // Pin from outside the clock domain.
  input wire logic SET_1000_I,
  // Datapath status, same clock.
  input wire logic TX_BUSY_I,
  input wire logic RX_BUSY_I,
  input wire logic RX_PADDED_I,
  input wire logic EXCESSIVE_COLLISION_FLAG_I,
  input wire logic PAUSE_RX_I,
  input wire logic [15:0] PAUSE_QUANTA_I,
  // Datapath control.
  output var mcc_pkg::mcc_cfg_t CFG_O,
  output var logic TX_HALT_O,
  output var logic RX_FIFO_FLUSH_O,
  output var logic STAT_CLEAR_O,
  // Interrupt.
  output var logic IRQ_O
);

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic access;
  logic done;
  logic wr;
  logic rd;
  logic [7:0] idx;
  logic hit;
  logic [31:0] rdata;

  logic [10:0] ctrl_q;
  logic excess_q;
  logic srst_q;
  mcc_pkg::mcc_srst_t st_q;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  logic [1:0] ev;

  assign access = PSEL_I & PENABLE_I;
  assign done = access & pready_q;
  assign wr = done & PWRITE_I;
  assign rd = done & ~PWRITE_I;
  assign idx = PADDR_I[9:2];
  assign hit = (PADDR_I[1:0] == 2'h0) &&
               (idx == mcc_pkg::IDX_CTRL || idx == mcc_pkg::IDX_IRQ_STAT ||
                idx == mcc_pkg::IDX_IRQ_MASK);

  always_comb begin
    rdata = 32'h0000_0000;
    if (PADDR_I[1:0] == 2'h0) begin
      case (idx)
        mcc_pkg::IDX_CTRL: begin
          rdata[10:0] = ctrl_q;
          rdata[mcc_pkg::BIT_EXCESS] = excess_q;
          rdata[mcc_pkg::BIT_SOFT_RESET_TRIGGER] = srst_q;
        end
        mcc_pkg::IDX_IRQ_STAT: begin
          rdata[1:0] = stat_q;
        end
        mcc_pkg::IDX_IRQ_MASK: begin
          rdata[1:0] = mask_q;
        end
        default: begin
          rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // Every access takes one wait state, so read data is latched a cycle
  // before the master samples it.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= access & ~pready_q;
      if (access & ~pready_q) begin
        prdata_q <= PWRITE_I ? 32'h0000_0000 : rdata;
        pslverr_q <= ~hit;
      end else begin
        prdata_q <= 32'h0000_0000;
        pslverr_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control word and soft reset sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctrl_q <= mcc_pkg::CTRL_RESET;
    end else if (st_q == mcc_pkg::SR_FLUSH) begin
      ctrl_q[mcc_pkg::BIT_TRANSMIT_PATH_ENABLE] <= 1'b0;
      ctrl_q[mcc_pkg::BIT_RECEIVE_PATH_ENABLE] <= 1'b0;
    end else if (wr && idx == mcc_pkg::IDX_CTRL && PADDR_I[1:0] == 2'h0) begin
      ctrl_q <= PWDATA_I[10:0];
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      srst_q <= 1'b0;
    end else if (st_q == mcc_pkg::SR_FLUSH) begin
      srst_q <= 1'b0;
    end else if (wr && idx == mcc_pkg::IDX_CTRL && PADDR_I[1:0] == 2'h0 &&
                 PWDATA_I[mcc_pkg::BIT_SOFT_RESET_TRIGGER]) begin
      srst_q <= 1'b1;
    end
  end

  // New frames may still start while draining; the datapath is expected
  // to hold off once the trigger bit reads back as one.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st_q <= mcc_pkg::SR_IDLE;
    end else begin
      case (st_q)
        mcc_pkg::SR_IDLE: begin
          if (srst_q) begin
            st_q <= mcc_pkg::SR_DRAIN;
          end
        end
        mcc_pkg::SR_DRAIN: begin
          if (!TX_BUSY_I && !RX_BUSY_I) begin
            st_q <= mcc_pkg::SR_FLUSH;
          end
        end
        mcc_pkg::SR_FLUSH: begin
          st_q <= mcc_pkg::SR_IDLE;
        end
        default: begin
          st_q <= mcc_pkg::SR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      RX_FIFO_FLUSH_O <= 1'b0;
      STAT_CLEAR_O <= 1'b0;
    end else begin
      RX_FIFO_FLUSH_O <= (st_q == mcc_pkg::SR_FLUSH);
      STAT_CLEAR_O <= (st_q == mcc_pkg::SR_FLUSH);
    end
  end

  // A collision event in the flush cycle still sets the flag.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      excess_q <= 1'b0;
    end else if (EXCESSIVE_COLLISION_FLAG_I) begin
      excess_q <= 1'b1;
    end else if (st_q == mcc_pkg::SR_FLUSH) begin
      excess_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Gigabit request pin synchroniser
  // ----------------------------------------------------------------------
  logic [2:0] sync_q;
  logic gig_req_q;

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sync_q <= 3'h0;
      gig_req_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], SET_1000_I};
      if (sync_q[1] == sync_q[2]) begin
        gig_req_q <= sync_q[2];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------------
  logic speed_bit;
  logic gig;

  assign speed_bit = ctrl_q[mcc_pkg::BIT_SPEED];
  assign gig = speed_bit | gig_req_q;

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      CFG_O <= '0;
    end else begin
      CFG_O.transmit_path_enable <= ctrl_q[mcc_pkg::BIT_TRANSMIT_PATH_ENABLE];
      CFG_O.receive_path_enable <= ctrl_q[mcc_pkg::BIT_RECEIVE_PATH_ENABLE];
      CFG_O.zero_quanta_pause_request <= ctrl_q[mcc_pkg::BIT_XON];
      CFG_O.gigabit_mode <= gig;
      CFG_O.half_duplex_select <= ctrl_q[mcc_pkg::BIT_HD] & ~speed_bit;
      CFG_O.accept_all_frames <= ctrl_q[mcc_pkg::BIT_PROMIS];
      CFG_O.pad_strip <= ctrl_q[mcc_pkg::BIT_PAD];
      CFG_O.fcs_passthrough <= ctrl_q[mcc_pkg::BIT_FCS_PASSTHROUGH] &
          ~(ctrl_q[mcc_pkg::BIT_PAD] & RX_PADDED_I);
      CFG_O.pause_frame_passthrough <= ctrl_q[mcc_pkg::BIT_PAUSE_FRAME_PASSTHROUGH];
      CFG_O.pause_ignore <= ctrl_q[mcc_pkg::BIT_PAUSE_IGN];
      CFG_O.source_address_overwrite <= ctrl_q[mcc_pkg::BIT_ADDR_INS];
    end
  end

  // ----------------------------------------------------------------------
  // Pause timer
  // ----------------------------------------------------------------------
  logic [15:0] qcnt_q;
  logic [7:0] sub_q;
  logic [7:0] per;

  // The quantum length follows the speed in force when it starts.
  assign per = gig ? mcc_pkg::QUANTUM_CYC_GIG : mcc_pkg::QUANTUM_CYC_FAST;

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      qcnt_q <= 16'h0000;
      sub_q <= 8'h00;
    end else if (PAUSE_RX_I && !ctrl_q[mcc_pkg::BIT_PAUSE_IGN]) begin
      qcnt_q <= PAUSE_QUANTA_I;
      sub_q <= per - 8'h01;
    end else if (qcnt_q != 16'h0000) begin
      if (sub_q == 8'h00) begin
        qcnt_q <= qcnt_q - 16'h0001;
        sub_q <= per - 8'h01;
      end else begin
        sub_q <= sub_q - 8'h01;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      TX_HALT_O <= 1'b0;
    end else begin
      TX_HALT_O <= (qcnt_q != 16'h0000);
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status, mask and output
  // ----------------------------------------------------------------------
  assign ev[mcc_pkg::IRQ_EXCESS] = EXCESSIVE_COLLISION_FLAG_I;
  assign ev[mcc_pkg::IRQ_SRST_DONE] = (st_q == mcc_pkg::SR_FLUSH);

  // Only the bits returned by the read are cleared, so an event landing
  // between data latch and completion survives.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      stat_q <= mcc_pkg::IRQ_RESET;
    end else if (rd && hit && idx == mcc_pkg::IDX_IRQ_STAT) begin
      stat_q <= (stat_q & ~prdata_q[1:0]) | ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      mask_q <= mcc_pkg::IRQ_RESET;
    end else if (wr && hit && idx == mcc_pkg::IDX_IRQ_MASK) begin
      mask_q <= PWDATA_I[1:0];
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(stat_q & mask_q);
    end
  end

  assign PRDATA_O = prdata_q;
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;

endmodule : mcc_top

`default_nettype wire

// *** rtl/mcc_pkg.sv ***
// Register map, field positions, timing constants and shared types of the MAC control word.
`default_nettype none

package mcc_pkg;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL = 8'h02;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h03;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h04;

  // ----------------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------------
  localparam int BIT_TRANSMIT_PATH_ENABLE = 0;
  localparam int BIT_RECEIVE_PATH_ENABLE = 1;
  localparam int BIT_XON = 2;
  localparam int BIT_SPEED = 3;
  localparam int BIT_PROMIS = 4;
  localparam int BIT_PAD = 5;
  localparam int BIT_FCS_PASSTHROUGH = 6;
  localparam int BIT_PAUSE_FRAME_PASSTHROUGH = 7;
  localparam int BIT_PAUSE_IGN = 8;
  localparam int BIT_ADDR_INS = 9;
  localparam int BIT_HD = 10;
  localparam int BIT_EXCESS = 11;
  localparam int BIT_SOFT_RESET_TRIGGER = 13;
  localparam int CTRL_RW_W = 11;
  localparam logic [10:0] CTRL_RESET = 11'h000;

  // ----------------------------------------------------------------------
  // Interrupt status and mask fields
  // ----------------------------------------------------------------------
  localparam int IRQ_W = 2;
  localparam int IRQ_EXCESS = 0;
  localparam int IRQ_SRST_DONE = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // ----------------------------------------------------------------------
  // Timing: one pause quantum is 512 bit times
  // ----------------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int QUANTUM_NS_GIG = 512;
  localparam int QUANTUM_NS_FAST = 5120;
  localparam logic [7:0] QUANTUM_CYC_GIG = 8'((QUANTUM_NS_GIG + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] QUANTUM_CYC_FAST = 8'((QUANTUM_NS_FAST + CLK_NS - 1) / CLK_NS);

  typedef struct packed {
    logic transmit_path_enable;
    logic receive_path_enable;
    logic zero_quanta_pause_request;
    logic gigabit_mode;
    logic half_duplex_select;
    logic accept_all_frames;
    logic pad_strip;
    logic fcs_passthrough;
    logic pause_frame_passthrough;
    logic pause_ignore;
    logic source_address_overwrite;
  } mcc_cfg_t;

  typedef enum logic [1:0] {
    SR_IDLE = 2'b00,
    SR_DRAIN = 2'b01,
    SR_FLUSH = 2'b10
  } mcc_srst_t;

endpackage : mcc_pkg

`default_nettype wire

// *** bench/mcc_top_checker.sv ***
// Port-level assertions for the MAC control word block.
`default_nettype none

module mcc_top_checker (
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  // Observed ports.
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [9:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic PREADY_O,
  input wire logic TX_BUSY_I,
  input wire logic RX_BUSY_I,
  input wire logic RX_PADDED_I,
  input wire logic PAUSE_RX_I,
  input wire logic [15:0] PAUSE_QUANTA_I,
  input wire mcc_pkg::mcc_cfg_t CFG_O,
  input wire logic TX_HALT_O,
  input wire logic RX_FIFO_FLUSH_O,
  input wire logic STAT_CLEAR_O
);
  logic wr_ctrl;
  logic busy;
  logic [31:0] wd_q;
  assign wr_ctrl = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I
                   && PADDR_I == {mcc_pkg::IDX_CTRL, 2'b00};
  assign busy = TX_BUSY_I || RX_BUSY_I;
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) wd_q <= 32'h0;
    else if (wr_ctrl) wd_q <= PWDATA_I;
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  chk_path_enables: assert property (wr_ctrl && !PWDATA_I[13] |-> ##2
    CFG_O.transmit_path_enable == wd_q[0] && CFG_O.receive_path_enable == wd_q[1])
    else $error("datapath enables do not follow the control word");
  chk_speed_forced: assert property (wr_ctrl |-> ##2 (!wd_q[3] || CFG_O.gigabit_mode))
    else $error("speed bit set but gigabit mode off");
  chk_half_duplex: assert property (wr_ctrl |-> ##2
    CFG_O.half_duplex_select == (wd_q[10] && !wd_q[3]))
    else $error("duplex selection wrong");
  chk_pad_fcs: assert property (CFG_O.pad_strip && RX_PADDED_I |=> !CFG_O.fcs_passthrough)
    else $error("fcs kept on a padded frame with pad removal");
  chk_pause_halt: assert property (PAUSE_RX_I && !CFG_O.pause_ignore && !TX_HALT_O
    && PAUSE_QUANTA_I != 16'h0000 |-> ##2 TX_HALT_O)
    else $error("pause frame did not halt transmit");
  chk_pause_ignored: assert property (PAUSE_RX_I && CFG_O.pause_ignore && !TX_HALT_O
    |-> ##2 !TX_HALT_O)
    else $error("ignored pause frame halted transmit");
  chk_flush_pair: assert property (RX_FIFO_FLUSH_O |-> STAT_CLEAR_O ##1 !RX_FIFO_FLUSH_O)
    else $error("flush and statistics clear not a paired single pulse");
  chk_flush_disables: assert property (RX_FIFO_FLUSH_O |-> ##[0:1]
    !CFG_O.transmit_path_enable && !CFG_O.receive_path_enable)
    else $error("enables still set after soft reset");
  chk_flush_idle: assert property ($rose(RX_FIFO_FLUSH_O) |-> $past(busy) == 1'b0)
    else $error("flush while a frame was in progress");
  cover property (RX_FIFO_FLUSH_O);
  cover property (TX_HALT_O);
  cover property (wr_ctrl && PWDATA_I[3]);
endmodule : mcc_top_checker

bind mcc_top mcc_top_checker i_chk (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PREADY_O(PREADY_O), .TX_BUSY_I(TX_BUSY_I), .RX_BUSY_I(RX_BUSY_I),
  .RX_PADDED_I(RX_PADDED_I), .PAUSE_RX_I(PAUSE_RX_I), .PAUSE_QUANTA_I(PAUSE_QUANTA_I),
  .CFG_O(CFG_O), .TX_HALT_O(TX_HALT_O), .RX_FIFO_FLUSH_O(RX_FIFO_FLUSH_O),
  .STAT_CLEAR_O(STAT_CLEAR_O));

`default_nettype wire

// *** bench/mcc_far_model.sv ***
// Behavioural model of the datapath and line side that reports frames to the block.
`default_nettype none

module mcc_far_model (
  // Clock.
  input wire logic clk_i,
  // Status toward the block.
  output var logic tx_busy_o,
  output var logic rx_busy_o,
  output var logic rx_padded_o,
  output var logic excessive_collision_flag_o,
  output var logic pause_rx_o,
  output var logic [15:0] quanta_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {tx_busy_o, rx_busy_o, rx_padded_o, excessive_collision_flag_o, pause_rx_o} = 5'h00;
    quanta_o = 16'h0000;
  end
  // A frame in progress holds busy so that a soft reset must wait for it.
  task automatic frame(input int n, input logic padded);
    @(posedge clk_i);
    {tx_busy_o, rx_busy_o, rx_padded_o} <= {2'b11, padded};
    repeat (n) @(posedge clk_i);
    {tx_busy_o, rx_busy_o, rx_padded_o} <= 3'h0;
  endtask : frame
  task automatic collide;
    @(posedge clk_i);
    excessive_collision_flag_o <= 1'b1;
    @(posedge clk_i);
    excessive_collision_flag_o <= 1'b0;
  endtask : collide
  // Quanta are only valid with the strobe; afterwards the lines carry junk.
  task automatic pause(input logic [15:0] q);
    @(posedge clk_i);
    pause_rx_o <= 1'b1;
    quanta_o <= q;
    @(posedge clk_i);
    pause_rx_o <= 1'b0;
    quanta_o <= ~q;
  endtask : pause
endmodule : mcc_far_model

`default_nettype wire

// *** bench/mcc_top_tb.sv ***
// Self-checking testbench of the MAC control word block.
`default_nettype none

module mcc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic set_1000 = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic [15:0] quanta;
  logic pready, pslverr, err, tx_busy, rx_busy, padded, col, prx, halt, flush, irq;
  mcc_pkg::mcc_cfg_t cfg;
  int n_errors = 0;
  int samples_checked = 0;
  int i, n;
  always #20 clk = ~clk;
  mcc_top i_dut (.CLK_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .SET_1000_I(set_1000), .TX_BUSY_I(tx_busy),
    .RX_BUSY_I(rx_busy), .RX_PADDED_I(padded), .EXCESSIVE_COLLISION_FLAG_I(col), .PAUSE_RX_I(prx),
    .PAUSE_QUANTA_I(quanta), .CFG_O(cfg), .TX_HALT_O(halt), .RX_FIFO_FLUSH_O(flush),
    .STAT_CLEAR_O(), .IRQ_O(irq));
  mcc_far_model i_far (.clk_i(clk), .tx_busy_o(tx_busy), .rx_busy_o(rx_busy),
    .rx_padded_o(padded), .excessive_collision_flag_o(col), .pause_rx_o(prx), .quanta_o(quanta));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Read data is taken at the rising edge that samples pready high, and only
  // then is the request released.
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, idx, 2'b00, wd};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++k < 20);
    if (k == 20) n_errors++;
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  function automatic logic [10:0] ecfg(input logic [31:0] c, input logic pin, input logic pad);
    return {c[0], c[1], c[2], c[3] | pin, c[10] & ~c[3], c[4], c[5], c[6] & ~(c[5] & pad),
            c[7], c[8], c[9]};
  endfunction : ecfg
  task automatic wcfg(input logic [31:0] d, input logic pin, input logic pad);
    apb(1'b1, mcc_pkg::IDX_CTRL, d);
    repeat (3) @(negedge clk);
    chk(32'(cfg), 32'(ecfg(d, pin, pad)));
  endtask : wcfg
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  initial begin
    #1ms;
    n_errors++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, mcc_pkg::IDX_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h3F, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("test reset and unmapped done");
    for (i = 0; i < 11; i++) begin
      wcfg(32'h1 << i, 1'b0, 1'b0);
      apb(1'b0, mcc_pkg::IDX_CTRL, 32'h0);
      chk(rd, 32'h1 << i);
    end
    $display("test field walk done");
    wcfg(32'h400, 1'b0, 1'b0);
    set_1000 <= 1'b1;
    repeat (8) @(negedge clk);
    chk(32'(cfg), 32'(ecfg(32'h400, 1'b1, 1'b0)));
    wcfg(32'h408, 1'b1, 1'b0);
    set_1000 <= 1'b0;
    repeat (8) @(negedge clk);
    chk(32'(cfg), 32'(ecfg(32'h408, 1'b0, 1'b0)));
    wcfg(32'h400, 1'b0, 1'b0);
    $display("test speed and duplex done");
    wcfg(32'h60, 1'b0, 1'b0);
    fork i_far.frame(10, 1'b1); join_none
    repeat (4) @(negedge clk);
    chk(32'(cfg), 32'(ecfg(32'h60, 1'b0, 1'b1)));
    repeat (10) @(negedge clk);
    chk(32'(cfg), 32'(ecfg(32'h60, 1'b0, 1'b0)));
    $display("test padding done");
    apb(1'b1, mcc_pkg::IDX_IRQ_MASK, 32'h1);
    wcfg(32'h800, 1'b0, 1'b0);
    i_far.collide();
    repeat (3) @(negedge clk);
    chk(irq, 1'b1);
    apb(1'b0, mcc_pkg::IDX_CTRL, 32'h0);
    chk(rd, 32'h800);
    apb(1'b0, mcc_pkg::IDX_IRQ_STAT, 32'h0);
    chk(rd, 32'h1);
    repeat (2) @(negedge clk);
    chk(irq, 1'b0);
    apb(1'b1, mcc_pkg::IDX_IRQ_MASK, 32'h0);
    i_far.collide();
    repeat (3) @(negedge clk);
    chk(irq, 1'b0);
    apb(1'b0, mcc_pkg::IDX_IRQ_STAT, 32'h0);
    chk(rd, 32'h1);
    $display("test collision flag and interrupt done");
    wcfg(32'h3, 1'b0, 1'b0);
    fork i_far.frame(30, 1'b0); join_none
    apb(1'b1, mcc_pkg::IDX_CTRL, 32'h2003);
    apb(1'b0, mcc_pkg::IDX_CTRL, 32'h0);
    chk(rd, 32'h2803);
    chk(cfg.transmit_path_enable, 1'b1);
    n = 0;
    while (flush !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk(n < 200, 1'b1);
    apb(1'b0, mcc_pkg::IDX_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, mcc_pkg::IDX_IRQ_STAT, 32'h0);
    chk(rd, 32'h2);
    $display("test soft reset done");
    wcfg(32'h3, 1'b0, 1'b0);
    i_far.pause(16'h0002);
    n = 0;
    while (halt !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (halt === 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk(n, 2 * mcc_pkg::QUANTUM_CYC_FAST);
    wcfg(32'h103, 1'b0, 1'b0);
    i_far.pause(16'h0002);
    repeat (4) @(negedge clk);
    chk(halt, 1'b0);
    $display("test pause done");
    summarize();
  end
endmodule : mcc_top_tb

`default_nettype wire
